// ==== verilog/jtd_pkg.sv ====
// constants, types and field layout for the transport deframer
// Behaviour
// - deframe link frames into samples per programmed parameters
// - octets per frame per lane 1, 2 or 4
// - K is 32 in modes 4/9, else 16/32
// - lane count 1, 2 or 4
// - converter count 1 or 2
// - samples per converter per frame 1 or 2
// - control words and control bits stay zero
// - high density set exactly when F is 1
// - resolution and bits per sample fixed at 16
// - only modes 4, 5, 6, 7, 9, 10
// - processing clock 250 MHz, frame clock times 4/F
// - count fields hold value minus one
// - plain octets field holds F, matches minus-one field
// - device and bank idents match transmitter
// - lane zero ident matches transmitter lane 0
// - version field 0 selects A, 1 selects B
// - status bit 5 flags illegal multiframe delay
// - status bit 3 flags unsupported L/M/F/S
// - status bit 2 flags illegal K
// - status bit 1 flags illegal subclass
// - deskew then enable bit per used lane
// - subclass field 0 or 1
// - lane count bit 7 enables descrambling
package jtd_pkg;

    localparam int ADDR_W = 12;
    localparam int LANES = 4;
    localparam int SAMPLE_W = 16;
    localparam int FIFO_DEPTH = 32;

    // register offsets
    localparam logic [11:0] OFS_CONFIG_CHECK_STATUS = 12'h030;
    localparam logic [11:0] OFS_LOCAL_MULTIFRAME_DELAY = 12'h304;
    localparam logic [11:0] OFS_LINK_DEVICE_IDENT = 12'h450;
    localparam logic [11:0] OFS_LINK_BANK_IDENT = 12'h451;
    localparam logic [11:0] OFS_LANE_ZERO_IDENT = 12'h452;
    localparam logic [11:0] OFS_LANE_COUNT_M1 = 12'h453;
    localparam logic [11:0] OFS_OCTETS_M1 = 12'h454;
    localparam logic [11:0] OFS_FRAMES_M1 = 12'h455;
    localparam logic [11:0] OFS_CONVERTERS_M1 = 12'h456;
    localparam logic [11:0] OFS_RESOLUTION_M1 = 12'h457;
    localparam logic [11:0] OFS_BITS_PER_SAMPLE_M1 = 12'h458;
    localparam logic [11:0] OFS_SAMPLES_AND_VERSION = 12'h459;
    localparam logic [11:0] OFS_DENSITY_FORMAT = 12'h45A;
    localparam logic [11:0] OFS_LANE_DESKEW_MASK = 12'h46C;
    localparam logic [11:0] OFS_OCTETS_PLAIN = 12'h476;
    localparam logic [11:0] OFS_LANE_ENABLE_MASK = 12'h47D;

    // writable bits per register; others read zero
    localparam logic [7:0] MSK_BANK_IDENT = 8'h0F;
    localparam logic [7:0] MSK_LANE_ZERO_IDENT = 8'h1F;
    localparam logic [7:0] MSK_LANE_COUNT = 8'h9F;
    localparam logic [7:0] MSK_FRAMES = 8'h1F;
    localparam logic [7:0] MSK_RESOLUTION = 8'hDF;
    localparam logic [7:0] MSK_DENSITY = 8'h9F;
    localparam logic [7:0] MSK_LANE_MASKS = 8'h0F;

    // reset values: a legal mode 4 setup
    localparam logic [7:0] RST_DEVICE_IDENT = 8'h00;
    localparam logic [7:0] RST_BANK_IDENT = 8'h00;
    localparam logic [7:0] RST_LANE_ZERO_IDENT = 8'h00;
    localparam logic [7:0] RST_LANE_COUNT = 8'h03;
    localparam logic [7:0] RST_OCTETS_M1 = 8'h00;
    localparam logic [7:0] RST_FRAMES_M1 = 8'h1F;
    localparam logic [7:0] RST_CONVERTERS_M1 = 8'h01;
    localparam logic [7:0] RST_RESOLUTION_M1 = 8'h0F;
    localparam logic [7:0] RST_BITS_PER_SAMPLE_M1 = 8'h0F;
    localparam logic [7:0] RST_SAMPLES_AND_VERSION = 8'h20;
    localparam logic [7:0] RST_DENSITY = 8'h80;
    localparam logic [7:0] RST_OCTETS_PLAIN = 8'h01;
    localparam logic [7:0] RST_LANE_MASKS = 8'h00;
    localparam logic [7:0] RST_MULTIFRAME_DELAY = 8'h00;

    // field positions
    localparam int BIT_STAT_MF_DELAY = 5;
    localparam int BIT_STAT_MODE = 3;
    localparam int BIT_STAT_FRAMES = 2;
    localparam int BIT_STAT_SUBCLASS = 1;
    localparam int BIT_SCRAMBLE = 7;
    localparam int BIT_DENSITY = 7;
    localparam int LSB_TOP3 = 5;
    localparam int MSB_COUNT = 4;
    localparam int MSB_CTRL_BITS = 7;
    localparam int LSB_CTRL_BITS = 6;

    // fixed and legal values
    localparam logic [4:0] SAMPLE_BITS_M1 = 5'h0F;
    localparam logic [4:0] FRAMES_16_M1 = 5'h0F;
    localparam logic [4:0] FRAMES_32_M1 = 5'h1F;
    localparam logic [2:0] SUBCLASS_MAX = 3'h1;

    typedef enum logic [3:0] {
        JTD_MODE_NONE = 4'h0,
        JTD_MODE_4 = 4'h4,
        JTD_MODE_5 = 4'h5,
        JTD_MODE_6 = 4'h6,
        JTD_MODE_7 = 4'h7,
        JTD_MODE_9 = 4'h9,
        JTD_MODE_10 = 4'hA
    } jtd_mode_e;

    typedef struct packed {
        logic conv;
        logic [SAMPLE_W-1:0] value;
    } jtd_sample_s;

    typedef struct packed {
        logic valid;
        logic frame_start;
        logic [8*LANES-1:0] octets;
    } jtd_lane_s;

endpackage

// ==== verilog/jtd_transport_deframer.sv ====
// transport deframer: link octets to converter samples, with sample FIFO
`timescale 1ns/100ps
`default_nettype none

module jtd_sample_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [0:DEPTH-1];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign in_ready = (count_q != (AW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem_q[rd_ptr_q];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

module jtd_transport_deframer (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // register port
    input wire logic [jtd_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // link side, from the data-link layer on its own clock
    input wire logic link_clk,
    input wire jtd_pkg::jtd_lane_s lane_in,
    // samples toward the converters
    output logic sample_valid,
    input wire logic sample_ready,
    output jtd_pkg::jtd_sample_s sample_out,
    // status toward the rest of the device
    output logic scramble_en,
    output jtd_pkg::jtd_mode_e active_mode,
    output logic deframe_active,
    output logic frame_drop
);
    import jtd_pkg::*;

    // registers
    logic [7:0] device_ident_q;
    logic [7:0] bank_ident_q;
    logic [7:0] lane_zero_ident_q;
    logic [7:0] lane_count_q;
    logic [7:0] octets_m1_q;
    logic [7:0] frames_m1_q;
    logic [7:0] converters_m1_q;
    logic [7:0] resolution_m1_q;
    logic [7:0] bits_per_sample_q;
    logic [7:0] samples_version_q;
    logic [7:0] density_q;
    logic [7:0] octets_plain_q;
    logic [7:0] deskew_mask_q;
    logic [7:0] lane_enable_q;
    logic [7:0] mf_delay_q;
    logic [7:0] status_q;
    logic [7:0] status_d;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            device_ident_q <= RST_DEVICE_IDENT;
            bank_ident_q <= RST_BANK_IDENT;
            lane_zero_ident_q <= RST_LANE_ZERO_IDENT;
            lane_count_q <= RST_LANE_COUNT;
            octets_m1_q <= RST_OCTETS_M1;
            frames_m1_q <= RST_FRAMES_M1;
            converters_m1_q <= RST_CONVERTERS_M1;
            resolution_m1_q <= RST_RESOLUTION_M1;
            bits_per_sample_q <= RST_BITS_PER_SAMPLE_M1;
            samples_version_q <= RST_SAMPLES_AND_VERSION;
            density_q <= RST_DENSITY;
            octets_plain_q <= RST_OCTETS_PLAIN;
            deskew_mask_q <= RST_LANE_MASKS;
            lane_enable_q <= RST_LANE_MASKS;
            mf_delay_q <= RST_MULTIFRAME_DELAY;
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_LINK_DEVICE_IDENT: device_ident_q <= reg_wdata;
                OFS_LINK_BANK_IDENT: bank_ident_q <= reg_wdata & MSK_BANK_IDENT;
                OFS_LANE_ZERO_IDENT: lane_zero_ident_q <= reg_wdata & MSK_LANE_ZERO_IDENT;
                OFS_LANE_COUNT_M1: lane_count_q <= reg_wdata & MSK_LANE_COUNT;
                OFS_OCTETS_M1: octets_m1_q <= reg_wdata;
                OFS_FRAMES_M1: frames_m1_q <= reg_wdata & MSK_FRAMES;
                OFS_CONVERTERS_M1: converters_m1_q <= reg_wdata;
                OFS_RESOLUTION_M1: resolution_m1_q <= reg_wdata & MSK_RESOLUTION;
                OFS_BITS_PER_SAMPLE_M1: bits_per_sample_q <= reg_wdata;
                OFS_SAMPLES_AND_VERSION: samples_version_q <= reg_wdata;
                OFS_DENSITY_FORMAT: density_q <= reg_wdata & MSK_DENSITY;
                OFS_OCTETS_PLAIN: octets_plain_q <= reg_wdata;
                OFS_LANE_DESKEW_MASK: deskew_mask_q <= reg_wdata & MSK_LANE_MASKS;
                OFS_LANE_ENABLE_MASK: lane_enable_q <= reg_wdata & MSK_LANE_MASKS;
                OFS_LOCAL_MULTIFRAME_DELAY: mf_delay_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // read data one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    OFS_CONFIG_CHECK_STATUS: reg_rdata <= status_q;
                    OFS_LINK_DEVICE_IDENT: reg_rdata <= device_ident_q;
                    OFS_LINK_BANK_IDENT: reg_rdata <= bank_ident_q;
                    OFS_LANE_ZERO_IDENT: reg_rdata <= lane_zero_ident_q;
                    OFS_LANE_COUNT_M1: reg_rdata <= lane_count_q;
                    OFS_OCTETS_M1: reg_rdata <= octets_m1_q;
                    OFS_FRAMES_M1: reg_rdata <= frames_m1_q;
                    OFS_CONVERTERS_M1: reg_rdata <= converters_m1_q;
                    OFS_RESOLUTION_M1: reg_rdata <= resolution_m1_q;
                    OFS_BITS_PER_SAMPLE_M1: reg_rdata <= bits_per_sample_q;
                    OFS_SAMPLES_AND_VERSION: reg_rdata <= samples_version_q;
                    OFS_DENSITY_FORMAT: reg_rdata <= density_q;
                    OFS_LANE_DESKEW_MASK: reg_rdata <= deskew_mask_q;
                    OFS_OCTETS_PLAIN: reg_rdata <= octets_plain_q;
                    OFS_LANE_ENABLE_MASK: reg_rdata <= lane_enable_q;
                    OFS_LOCAL_MULTIFRAME_DELAY: reg_rdata <= mf_delay_q;
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    assign scramble_en = lane_count_q[BIT_SCRAMBLE];

    // configuration check, recomputed from live register contents
    logic [4:0] lanes_m1;
    logic [4:0] samples_m1;
    logic [4:0] frames_m1;
    logic [2:0] subclass;
    logic hd_bit;
    logic aux_bad;
    jtd_mode_e mode_d;

    assign lanes_m1 = lane_count_q[MSB_COUNT:0];
    assign samples_m1 = samples_version_q[MSB_COUNT:0];
    assign frames_m1 = frames_m1_q[MSB_COUNT:0];
    assign subclass = bits_per_sample_q[7:LSB_TOP3];
    assign hd_bit = density_q[BIT_DENSITY];

    always_comb begin
        mode_d = JTD_MODE_NONE;
        case ({converters_m1_q, lanes_m1, samples_m1, octets_m1_q})
            {8'h01, 5'h03, 5'h00, 8'h00}: mode_d = JTD_MODE_4;
            {8'h01, 5'h03, 5'h01, 8'h01}: mode_d = JTD_MODE_5;
            {8'h01, 5'h01, 5'h00, 8'h01}: mode_d = JTD_MODE_6;
            {8'h01, 5'h00, 5'h00, 8'h03}: mode_d = JTD_MODE_7;
            {8'h00, 5'h01, 5'h00, 8'h00}: mode_d = JTD_MODE_9;
            {8'h00, 5'h00, 5'h00, 8'h01}: mode_d = JTD_MODE_10;
            default: mode_d = JTD_MODE_NONE;
        endcase
    end

    // parameters that no mode tolerates are folded into the mode flag
    assign aux_bad = (resolution_m1_q[MSB_COUNT:0] != SAMPLE_BITS_M1)
        || (bits_per_sample_q[MSB_COUNT:0] != SAMPLE_BITS_M1)
        || (resolution_m1_q[MSB_CTRL_BITS:LSB_CTRL_BITS] != 2'h0)
        || (density_q[MSB_COUNT:0] != 5'h00)
        || (hd_bit != (octets_m1_q == 8'h00))
        || (octets_plain_q != octets_m1_q + 8'h01);

    always_comb begin
        status_d = 8'h00;
        status_d[BIT_STAT_MF_DELAY] = (mf_delay_q > {3'b000, frames_m1});
        status_d[BIT_STAT_MODE] = (mode_d == JTD_MODE_NONE) || aux_bad;
        status_d[BIT_STAT_FRAMES] = !((frames_m1 == FRAMES_32_M1)
            || (frames_m1 == FRAMES_16_M1 && octets_m1_q != 8'h00));
        status_d[BIT_STAT_SUBCLASS] = (subclass > SUBCLASS_MAX);
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            status_q <= 8'h00;
            active_mode <= JTD_MODE_NONE;
        end else begin
            status_q <= status_d;
            active_mode <= mode_d;
        end
    end

    // lanes 0..L-1 must be deskewed and enabled; unused lanes stay off
    logic [LANES-1:0] need_lanes;
    logic lanes_ok;
    always_comb begin
        unique case (lanes_m1[1:0])
            2'h0: need_lanes = 4'h1;
            2'h1: need_lanes = 4'h3;
            default: need_lanes = 4'hF;
        endcase
    end
    assign lanes_ok = (deskew_mask_q[LANES-1:0] == need_lanes)
        && (lane_enable_q[LANES-1:0] == need_lanes);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            deframe_active <= 1'b0;
        end else begin
            deframe_active <= (status_d == 8'h00) && lanes_ok;
        end
    end

    // link inputs cross by two flops; link clock edges found on the second
    logic lclk_s1;
    logic lclk_s2;
    logic lclk_s3;
    jtd_lane_s lane_s1;
    jtd_lane_s lane_s2;
    logic link_edge;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            lclk_s1 <= 1'b0;
            lclk_s2 <= 1'b0;
            lclk_s3 <= 1'b0;
            lane_s1 <= '0;
            lane_s2 <= '0;
        end else begin
            lclk_s1 <= link_clk;
            lclk_s2 <= lclk_s1;
            lclk_s3 <= lclk_s2;
            lane_s1 <= lane_in;
            lane_s2 <= lane_s1;
        end
    end
    assign link_edge = lclk_s2 & ~lclk_s3;

    // frame gather: octet k of lane n lands at byte n*4+k
    logic [1:0] octet_idx_q;
    logic [8*LANES*4-1:0] gather_q;
    logic [8*LANES*4-1:0] hold_q;
    logic frame_done;
    logic [1:0] f_last;

    assign f_last = octets_m1_q[1:0];
    assign frame_done = link_edge && lane_s2.valid && deframe_active
        && ((lane_s2.frame_start ? 2'h0 : octet_idx_q) == f_last);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            octet_idx_q <= 2'h0;
            gather_q <= '0;
        end else if (link_edge && lane_s2.valid && deframe_active) begin
            for (int n = 0; n < LANES; n++) begin
                gather_q[(n*4 + int'(lane_s2.frame_start ? 2'h0 : octet_idx_q))*8 +: 8]
                    <= lane_s2.octets[n*8 +: 8];
            end
            octet_idx_q <= frame_done ? 2'h0 : (lane_s2.frame_start ? 2'h1 : octet_idx_q + 2'h1);
        end else if (!deframe_active) begin
            octet_idx_q <= 2'h0;
        end
    end

    // emit M*S samples per frame into the FIFO; fifo full stalls the emitter
    logic emit_busy_q;
    logic [1:0] emit_idx_q;
    logic [1:0] emit_last;
    logic fifo_in_ready;
    logic emit_take;
    jtd_sample_s emit_word;
    logic [3:0] byte_hi;
    logic [3:0] byte_lo;
    logic [2:0] f_shift;

    // F in {1,2,4}: lane index is byte >> log2(F)
    assign f_shift = (f_last == 2'h0) ? 3'd0 : ((f_last == 2'h1) ? 3'd1 : 3'd2);
    assign emit_last = {converters_m1_q[0] & samples_m1[0],
        converters_m1_q[0] | samples_m1[0]};
    assign emit_take = emit_busy_q & fifo_in_ready;

    function automatic logic [3:0] byte_slot(input logic [2:0] idx, input logic [2:0] shift);
        logic [2:0] lane;
        logic [2:0] oct;
        lane = idx >> shift;
        oct = idx & ((3'd1 << shift) - 3'd1);
        byte_slot = {lane[1:0], oct[1:0]};
    endfunction

    // samples run converter-major, MSB octet first, across lanes when split
    assign byte_hi = byte_slot({emit_idx_q, 1'b0}, f_shift);
    assign byte_lo = byte_slot({emit_idx_q, 1'b1}, f_shift);
    assign emit_word.conv = samples_m1[0] ? emit_idx_q[1] : emit_idx_q[0];
    assign emit_word.value = {hold_q[int'(byte_hi)*8 +: 8], hold_q[int'(byte_lo)*8 +: 8]};

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            emit_busy_q <= 1'b0;
            emit_idx_q <= 2'h0;
            hold_q <= '0;
            frame_drop <= 1'b0;
        end else begin
            frame_drop <= 1'b0;
            if (emit_take) begin
                emit_idx_q <= (emit_idx_q == emit_last) ? 2'h0 : emit_idx_q + 2'h1;
                if (emit_idx_q == emit_last) begin
                    emit_busy_q <= 1'b0;
                end
            end
            if (frame_done) begin
                // a frame finished while the previous one is stuck is lost
                if (emit_busy_q && !(emit_take && emit_idx_q == emit_last)) begin
                    frame_drop <= 1'b1;
                end else begin
                    hold_q <= gather_q;
                    // last octets land in gather_q this same edge
                    for (int n = 0; n < LANES; n++) begin
                        hold_q[(n*4 + int'(f_last))*8 +: 8] <= lane_s2.octets[n*8 +: 8];
                    end
                    emit_busy_q <= 1'b1;
                    emit_idx_q <= 2'h0;
                end
            end
        end
    end

    jtd_sample_fifo #(
        .WIDTH($bits(jtd_sample_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .in_valid(emit_busy_q),
        .in_ready(fifo_in_ready),
        .in_data(emit_word),
        .out_valid(sample_valid),
        .out_ready(sample_ready),
        .out_data(sample_out)
    );

endmodule

`default_nettype wire

// ==== verif/jtd_deframer_checker.sv ====
// assertions on the deframer's register, sample and status ports
`timescale 1ns/100ps
`default_nettype none
module jtd_deframer_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // register port
    input wire logic [jtd_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // samples and status
    input wire logic sample_valid,
    input wire logic sample_ready,
    input wire jtd_pkg::jtd_sample_s sample_out,
    input wire logic scramble_en,
    input wire jtd_pkg::jtd_mode_e active_mode,
    input wire logic deframe_active,
    input wire logic frame_drop
);
    import jtd_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    rd_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    rd_quiet_a: assert property (!reg_rd |=> !reg_rvalid)
        else $error("read answer without read");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without read");
    unmapped_zero_a: assert property (reg_rd && reg_addr == 12'h123 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    scramble_on_a: assert property (reg_wr && reg_addr == 12'h453 && reg_wdata[7] |=> scramble_en)
        else $error("descrambling not enabled");
    scramble_off_a: assert property (reg_wr && reg_addr == 12'h453 && !reg_wdata[7] |=> !scramble_en)
        else $error("descrambling not disabled");
    mode_legal_a: assert property (active_mode inside {JTD_MODE_NONE, JTD_MODE_4, JTD_MODE_5,
        JTD_MODE_6, JTD_MODE_7, JTD_MODE_9, JTD_MODE_10})
        else $error("unsupported mode reported");
    active_mode_a: assert property (deframe_active |-> active_mode != JTD_MODE_NONE)
        else $error("deframing without a mode");
    drop_pulse_a: assert property (frame_drop |=> !frame_drop)
        else $error("drop pulse too long");
    sample_hold_a: assert property (sample_valid && !sample_ready |=> sample_valid && $stable(sample_out))
        else $error("stalled sample changed");
endmodule
`default_nettype wire

// ==== verif/jtd_tx_model.sv ====
// link transmitter model: one octet per lane per link clock, clock idle between frames
`timescale 1ns/100ps
`default_nettype none
module jtd_tx_model (
    // link side
    output logic link_clk,
    output jtd_pkg::jtd_lane_s lane_in
);
    import jtd_pkg::*;
    initial begin
        link_clk = 1'b0;
        lane_in = '0;
    end
    // b[n*f+k] is octet k of lane n; a sample is two whole octets, no control bits
    task automatic send_frame(input logic [7:0] b[16], input int f);
        for (int k = 0; k < f; k++) begin
            lane_in.valid = 1'b1;
            lane_in.frame_start = (k == 0);
            for (int n = 0; n < LANES; n++) begin
                lane_in.octets[8*n +: 8] = b[n*f+k];
            end
            #80 link_clk = 1'b1;
            #80 link_clk = 1'b0;
        end
        // released lines must not look like stale data
        lane_in.valid = 1'b0;
        lane_in.frame_start = 1'b0;
        lane_in.octets = ~lane_in.octets;
    endtask
endmodule
`default_nettype wire

// ==== verif/tb_jtd_transport_deframer.sv ====
// self-checking bench: registers, configuration checks and every mode's deframing
`timescale 1ns/100ps
`default_nettype none
module tb_jtd_transport_deframer;
    import jtd_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = '0;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic link_clk;
    jtd_lane_s lane_in;
    logic sample_valid;
    logic sample_ready = 1'b0;
    jtd_sample_s sample_out;
    logic scramble_en;
    jtd_mode_e active_mode;
    logic deframe_active;
    logic frame_drop;
    logic stall = 1'b1;
    int err_count = 0;
    int n_checks = 0;
    logic [7:0] exp_reg[$];
    jtd_sample_s exp_smp[$];
    // {addr, reset, writable mask}
    logic [27:0] rt[15] = '{28'h45000FF, 28'h451000F, 28'h452001F, 28'h453039F, 28'h45400FF,
        28'h4551F1F, 28'h45601FF, 28'h4570FDF, 28'h4580FFF, 28'h45920FF, 28'h45A809F,
        28'h46C000F, 28'h47601FF, 28'h47D000F, 28'h30400FF};
    // {addr, bad, good, status}
    logic [35:0] ct[8] = '{36'h4550F1F04, 36'h4584F0F02, 36'h304200020, 36'h456000108,
        36'h45A008008, 36'h476020108, 36'h4574F0F08, 36'h4580E0F08};
    // {mode, L, F, M, S}
    logic [19:0] mt[6] = '{20'h44121, 20'h54222, 20'h62221, 20'h71421, 20'h92111, 20'hA1211};

    jtd_transport_deframer DUT (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .link_clk(link_clk), .lane_in(lane_in),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_out(sample_out),
        .scramble_en(scramble_en), .active_mode(active_mode),
        .deframe_active(deframe_active), .frame_drop(frame_drop));
    jtd_tx_model tx (.link_clk(link_clk), .lane_in(lane_in));

    always #5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) sample_ready <= !stall && ($urandom_range(3) != 0);

    task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    always @(posedge sys_clk) begin
        if (reg_rvalid === 1'b1)
            check("read", (exp_reg.size() != 0) ? exp_reg.pop_front() : 17'h1FFFF, reg_rdata);
        if (sample_valid === 1'b1 && sample_ready === 1'b1)
            check("sample", (exp_smp.size() != 0) ? exp_smp.pop_front() : 17'h1FFFF, sample_out);
        if (nrst && frame_drop !== 1'b0) check("drop", 17'h0, 17'(frame_drop));
    end

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        exp_reg.push_back(e);
        @(negedge sys_clk);
        reg_rd = 1'b0;
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // bounded wait until every noted result has been seen
    task automatic drain(input string name);
        int i;
        for (i = 0; i < 3000 && exp_reg.size() + exp_smp.size() != 0; i++) @(negedge sys_clk);
        if (i == 3000) begin
            err_count++;
            $display("MISMATCH pending expected 0 seen %0d", exp_reg.size() + exp_smp.size());
            finish_test();
        end
        $display("test %s done", name);
    endtask

    initial begin
        logic [7:0] d;
        logic [7:0] b[16];
        jtd_sample_s s;
        int l;
        int f;
        void'($urandom(79879));
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        nrst = 1'b1;
        rd(12'h030, 8'h00);
        wr(12'h030, 8'hFF);
        wr(12'h123, 8'hFF);
        rd(12'h123, 8'h00);
        for (int i = 0; i < 15; i++) begin
            d = 8'($urandom);
            rd(rt[i][27:16], rt[i][15:8]);
            wr(rt[i][27:16], d);
            rd(rt[i][27:16], d & rt[i][7:0]);
            wr(rt[i][27:16], rt[i][15:8]);
        end
        repeat (2) @(negedge sys_clk);
        rd(12'h030, 8'h00);
        drain("registers");
        wr(12'h453, 8'h83);
        wr(12'h453, 8'h03);
        for (int i = 0; i < 8; i++) begin
            wr(ct[i][35:24], ct[i][23:16]);
            repeat (2) @(negedge sys_clk);
            rd(12'h030, ct[i][7:0]);
            wr(ct[i][35:24], ct[i][15:8]);
            repeat (2) @(negedge sys_clk);
            rd(12'h030, 8'h00);
        end
        drain("checks");
        for (int m = 0; m < 6; m++) begin
            l = mt[m][15:12];
            f = mt[m][11:8];
            wr(12'h453, {4'h0, mt[m][15:12] - 4'h1});
            wr(12'h454, {4'h0, mt[m][11:8] - 4'h1});
            wr(12'h476, {4'h0, mt[m][11:8]});
            wr(12'h456, {4'h0, mt[m][7:4] - 4'h1});
            wr(12'h459, {4'h2, mt[m][3:0] - 4'h1});
            wr(12'h45A, (f == 1) ? 8'h80 : 8'h00);
            wr(12'h46C, 8'((1 << l) - 1));
            wr(12'h47D, 8'((1 << l) - 1));
            repeat (3) @(negedge sys_clk);
            check("mode", 17'(mt[m][19:16]), 17'(active_mode));
            check("active", 17'h1, 17'(deframe_active));
            stall = 1'b1;
            repeat (3) begin
                for (int i = 0; i < 16; i++) b[i] = 8'($urandom);
                for (int j = 0; j < l * f / 2; j++) begin
                    s.conv = (mt[m][3:0] == 4'h2) ? j[1] : j[0];
                    s.value = {b[2*j], b[2*j+1]};
                    exp_smp.push_back(s);
                end
                tx.send_frame(b, f);
            end
            stall = 1'b0;
            drain("mode");
        end
        finish_test();
    end

    initial begin
        #1000000;
        err_count++;
        $display("MISMATCH run time expected done seen running");
        finish_test();
    end
endmodule

bind jtd_transport_deframer jtd_deframer_checker chk (.sys_clk(sys_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_out(sample_out), .scramble_en(scramble_en),
    .active_mode(active_mode), .deframe_active(deframe_active), .frame_drop(frame_drop));
`default_nettype wire
